// file: ebpm_pkg.sv
// Purpose: constants for the external bus control pin mux
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register indices of the plain register port
package ebpm_pkg;
  localparam int EBPM_NPINS = 7;
  localparam int EBPM_AW = 4;
  localparam logic [3:0] EBPM_REG_MODE = 4'h0;
  localparam logic [3:0] EBPM_REG_DATA = 4'h1;
  localparam logic [3:0] EBPM_REG_DIR = 4'h2;
  localparam logic [3:0] EBPM_REG_PULL = 4'h3;
  localparam logic [3:0] EBPM_REG_PIN = 4'h4;
  localparam logic [3:0] EBPM_REG_STATUS = 4'h5;
  localparam logic [3:0] EBPM_REG_ALT = 4'h6;
  // mode register field positions
  localparam int EBPM_MODE_EXTBUS = 0;
  localparam int EBPM_MODE_WIDE16 = 1;
  localparam int EBPM_MODE_LWS_EN = 2;
  localparam int EBPM_MODE_HWS_EN = 3;
  localparam int EBPM_MODE_HOLD_EN = 4;
  localparam int EBPM_MODE_RDY_EN = 5;
  localparam int EBPM_MODE_W = 6;
  // alternate output field positions (compare outputs 4..6)
  localparam int EBPM_ALT_COMPARE_OUTPUT_4 = 0;
  localparam int EBPM_ALT_COMPARE_OUTPUT_5 = 1;
  localparam int EBPM_ALT_COMPARE_OUTPUT_6 = 2;
  localparam int EBPM_ALT_W = 3;
  // pin positions within port 3
  localparam int EBPM_P_ALE = 0;
  localparam int EBPM_P_RD = 1;
  localparam int EBPM_P_LWS = 2;
  localparam int EBPM_P_HWS = 3;
  localparam int EBPM_P_HREQ = 4;
  localparam int EBPM_P_HGNT = 5;
  localparam int EBPM_P_RDY = 6;
  localparam logic [5:0] EBPM_MODE_RST = 6'h00;
  localparam logic [6:0] EBPM_PORT_RST = 7'h00;
  localparam logic [2:0] EBPM_ALT_RST = 3'h0;
endpackage

// file: ebpm_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs come from outside the clock domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ebpm_sync #(
  parameter int W = 7
) (
  input wire logic i_clk, // clock
  input wire logic i_reset, // sync reset
  input wire logic [W-1:0] i_async, // raw pin levels
  output logic [W-1:0] o_sync // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ebpm_sync_state_type;
  ebpm_sync_state_type st_ff, nxt_st;
  always_comb begin
    nxt_st.meta = i_async;
    nxt_st.sync = st_ff.meta;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_sync = st_ff.sync;
endmodule
`default_nettype wire

// file: ebpm_pin_mux.sv
// Purpose: port 3 pin mux between GPIO and external bus control
// Assumes: bus controller on i_clk; pins pass a two-flop synchroniser
// Notes: strobes are driven active low; pull-ups only in single-chip
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ebpm_pin_mux
  import ebpm_pkg::*;
(
  input wire logic i_clk, // 100 MHz clock
  input wire logic i_reset, // sync reset, active high
  input wire logic [EBPM_AW-1:0] i_addr, // register index
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after i_rd
  input wire logic i_bc_ale, // controller address latch enable
  input wire logic i_bc_rd_n, // controller read strobe, low active
  input wire logic i_bc_wr_n, // controller write strobe, low active
  input wire logic [1:0] i_bc_be, // byte lanes of write, bit1 high
  input wire logic i_bc_busy, // controller in a bus cycle
  input wire logic [2:0] i_cmp_out, // compare outputs 4..6
  output logic o_bc_hold_req, // hold request to controller
  output logic o_bc_hold_grant, // bus released, controller idle
  output logic o_bc_ready, // ready to controller, high = go on
  output logic o_cap_in4, // capture input 4
  output logic o_cap_in5, // capture input 5
  output logic o_ext_irq10_alt_input, // interrupt request input
  input wire logic [EBPM_NPINS-1:0] i_pin, // port 3 pad levels
  output logic [EBPM_NPINS-1:0] o_pin, // port 3 pad outputs
  output logic [EBPM_NPINS-1:0] o_pin_oe, // high while driven
  output logic [EBPM_NPINS-1:0] o_pin_pu // pull-up enables
);
  typedef struct packed {
    logic [EBPM_MODE_W-1:0] mode;
    logic [EBPM_NPINS-1:0] data;
    logic [EBPM_NPINS-1:0] dir;
    logic [EBPM_NPINS-1:0] pull;
    logic [EBPM_ALT_W-1:0] alt;
    logic [7:0] rdata;
    logic hold_ack;
    logic [EBPM_NPINS-1:0] pin_o;
    logic [EBPM_NPINS-1:0] pin_oe;
    logic [EBPM_NPINS-1:0] pin_pu;
    logic hold_req;
    logic ready;
    logic cap4;
    logic cap5;
    logic irq10;
  } ebpm_state_type;

  ebpm_state_type st_ff, nxt_st;
  logic [EBPM_NPINS-1:0] pin_sync;
  logic ext_bus, wide16, lws_on, hws_on, hold_on, rdy_on;
  logic [EBPM_NPINS-1:0] alt_sel;

  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  ebpm_sync #(
    .W(EBPM_NPINS)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(i_pin),
    .o_sync(pin_sync)
  );

  always_comb begin
    ext_bus = st_ff.mode[EBPM_MODE_EXTBUS];
    wide16 = st_ff.mode[EBPM_MODE_WIDE16];
    lws_on = ext_bus & st_ff.mode[EBPM_MODE_LWS_EN];
    hws_on = ext_bus & wide16 & st_ff.mode[EBPM_MODE_HWS_EN];
    hold_on = ext_bus & st_ff.mode[EBPM_MODE_HOLD_EN];
    rdy_on = ext_bus & st_ff.mode[EBPM_MODE_RDY_EN];
    alt_sel = '0;
    alt_sel[EBPM_P_ALE] = ext_bus;
    alt_sel[EBPM_P_RD] = ext_bus;
    alt_sel[EBPM_P_LWS] = lws_on;
    alt_sel[EBPM_P_HWS] = hws_on;
    alt_sel[EBPM_P_HREQ] = hold_on;
    alt_sel[EBPM_P_HGNT] = hold_on;
    alt_sel[EBPM_P_RDY] = rdy_on;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    if (i_wr) begin
      case (i_addr)
        EBPM_REG_MODE: nxt_st.mode = i_wdata[EBPM_MODE_W-1:0];
        EBPM_REG_DATA: nxt_st.data = i_wdata[EBPM_NPINS-1:0];
        EBPM_REG_DIR: nxt_st.dir = i_wdata[EBPM_NPINS-1:0];
        EBPM_REG_PULL: nxt_st.pull = i_wdata[EBPM_NPINS-1:0];
        EBPM_REG_ALT: nxt_st.alt = i_wdata[EBPM_ALT_W-1:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        EBPM_REG_MODE: nxt_st.rdata = {2'h0, st_ff.mode};
        EBPM_REG_DATA: nxt_st.rdata = {1'h0, st_ff.data};
        EBPM_REG_DIR: nxt_st.rdata = {1'h0, st_ff.dir};
        EBPM_REG_PULL: nxt_st.rdata = {1'h0, st_ff.pull};
        EBPM_REG_PIN: nxt_st.rdata = {1'h0, pin_sync};
        EBPM_REG_STATUS: nxt_st.rdata = {5'h00, st_ff.ready,
                                         st_ff.hold_ack, st_ff.hold_req};
        EBPM_REG_ALT: nxt_st.rdata = {5'h00, st_ff.alt};
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // GPIO default for every pin
    nxt_st.pin_o = st_ff.data;
    nxt_st.pin_oe = st_ff.dir;
    if (st_ff.alt[EBPM_ALT_COMPARE_OUTPUT_4] && !hold_on) begin
      nxt_st.pin_o[EBPM_P_HREQ] = i_cmp_out[0];
      nxt_st.pin_oe[EBPM_P_HREQ] = 1'b1;
    end
    if (st_ff.alt[EBPM_ALT_COMPARE_OUTPUT_5] && !hold_on) begin
      nxt_st.pin_o[EBPM_P_HGNT] = i_cmp_out[1];
      nxt_st.pin_oe[EBPM_P_HGNT] = 1'b1;
    end
    if (st_ff.alt[EBPM_ALT_COMPARE_OUTPUT_6] && !rdy_on) begin
      nxt_st.pin_o[EBPM_P_RDY] = i_cmp_out[2];
      nxt_st.pin_oe[EBPM_P_RDY] = 1'b1;
    end
    if (ext_bus) begin
      nxt_st.pin_o[EBPM_P_ALE] = i_bc_ale;
      nxt_st.pin_oe[EBPM_P_ALE] = 1'b1;
    end
    if (ext_bus) begin
      nxt_st.pin_o[EBPM_P_RD] = i_bc_rd_n;
      nxt_st.pin_oe[EBPM_P_RD] = 1'b1;
    end
    // low write strobe; low byte in 16-bit
    if (lws_on) begin
      nxt_st.pin_o[EBPM_P_LWS] = wide16 ? (i_bc_wr_n | ~i_bc_be[0])
                                        : i_bc_wr_n;
      nxt_st.pin_oe[EBPM_P_LWS] = 1'b1;
    end
    if (hws_on) begin
      nxt_st.pin_o[EBPM_P_HWS] = i_bc_wr_n | ~i_bc_be[1];
      nxt_st.pin_oe[EBPM_P_HWS] = 1'b1;
    end
    // hold request pin input only when hold on
    if (hold_on) begin
      nxt_st.pin_oe[EBPM_P_HREQ] = 1'b0;
    end
    if (hold_on) begin
      nxt_st.pin_o[EBPM_P_HGNT] = ~st_ff.hold_ack;
      nxt_st.pin_oe[EBPM_P_HGNT] = 1'b1;
    end
    // ready pin input only when enabled
    if (rdy_on) begin
      nxt_st.pin_oe[EBPM_P_RDY] = 1'b0;
    end
    nxt_st.pin_pu = ext_bus ? '0 : (st_ff.pull & ~st_ff.dir);

    // hold request sampled only when enabled
    nxt_st.hold_req = hold_on & pin_sync[EBPM_P_HREQ];
    // ack after current cycle ends; drop with request
    if (!hold_on || !st_ff.hold_req) begin
      nxt_st.hold_ack = 1'b0;
    end else if (!i_bc_busy) begin
      nxt_st.hold_ack = 1'b1;
    end
    // ready low inserts waits; device holds it
    nxt_st.ready = rdy_on ? pin_sync[EBPM_P_RDY] : 1'b1;
    nxt_st.cap4 = pin_sync[EBPM_P_ALE] & ~alt_sel[EBPM_P_ALE];
    nxt_st.cap5 = pin_sync[EBPM_P_RD] & ~alt_sel[EBPM_P_RD];
    nxt_st.irq10 = pin_sync[EBPM_P_LWS] & ~alt_sel[EBPM_P_LWS];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= '0;
      st_ff.mode <= EBPM_MODE_RST;
      st_ff.data <= EBPM_PORT_RST;
      st_ff.dir <= EBPM_PORT_RST;
      st_ff.pull <= EBPM_PORT_RST;
      st_ff.alt <= EBPM_ALT_RST;
      st_ff.ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_pin = st_ff.pin_o;
  assign o_pin_oe = st_ff.pin_oe;
  assign o_pin_pu = st_ff.pin_pu;
  assign o_bc_hold_req = st_ff.hold_req;
  assign o_bc_hold_grant = st_ff.hold_ack;
  assign o_bc_ready = st_ff.ready;
  assign o_cap_in4 = st_ff.cap4;
  assign o_cap_in5 = st_ff.cap5;
  assign o_ext_irq10_alt_input = st_ff.irq10;

  // assertions: clock comes from the default clocking above, reset from the default disable iff

  // bus pins owned by the controller in external bus mode
  AST_ALE_DRIVE: assert property (
    ext_bus |=>
    o_pin_oe[EBPM_P_ALE] && o_pin[EBPM_P_ALE] == $past(i_bc_ale))
    else $error("ale not driven");
  AST_ALE_GPIO: assert property (
    !ext_bus |=> o_pin[EBPM_P_ALE] == $past(st_ff.data[EBPM_P_ALE])
    && o_pin_oe[EBPM_P_ALE] == $past(st_ff.dir[EBPM_P_ALE]))
    else $error("ale pin not gpio in single-chip");
  AST_RD_DRIVE: assert property (
    ext_bus |=>
    o_pin_oe[EBPM_P_RD] && o_pin[EBPM_P_RD] == $past(i_bc_rd_n))
    else $error("read strobe not driven");
  AST_RD_GPIO: assert property (
    !ext_bus |=> o_pin[EBPM_P_RD] == $past(st_ff.data[EBPM_P_RD])
    && o_pin_oe[EBPM_P_RD] == $past(st_ff.dir[EBPM_P_RD]))
    else $error("read strobe pin not gpio in single-chip");
  AST_LWS_GPIO: assert property (
    !lws_on |=>
    o_pin_oe[EBPM_P_LWS] == $past(st_ff.dir[EBPM_P_LWS]))
    else $error("low strobe pin not gpio");
  AST_LWS_OE: assert property (
    lws_on |=>
    o_pin_oe[EBPM_P_LWS])
    else $error("low strobe pin not driven");
  AST_LWS_16: assert property (
    lws_on && wide16 && !i_bc_wr_n && !i_bc_be[0] |=>
    o_pin[EBPM_P_LWS])
    else $error("low strobe fired without low lane");
  AST_LWS_8: assert property (
    lws_on && !wide16 |=>
    o_pin[EBPM_P_LWS] == $past(i_bc_wr_n))
    else $error("byte strobe wrong");
  AST_HWS_DRIVE: assert property (
    o_pin_oe[EBPM_P_HWS] && !$past(st_ff.dir[EBPM_P_HWS]) |->
    $past(hws_on))
    else $error("high strobe driven without 16-bit bus");
  AST_HWS_16: assert property (
    hws_on && !i_bc_wr_n && i_bc_be[1] |=>
    !o_pin[EBPM_P_HWS])
    else $error("high strobe missing for upper lane");
  AST_HWS_GPIO: assert property (
    !wide16 |=>
    o_pin[EBPM_P_HWS] == $past(st_ff.data[EBPM_P_HWS]))
    else $error("high strobe pin not gpio in 8-bit");
  AST_HWS_OFF: assert property (
    !hws_on |=>
    o_pin_oe[EBPM_P_HWS] == $past(st_ff.dir[EBPM_P_HWS]))
    else $error("high strobe pin driven while off");

  // hold handshake with an outside requester
  AST_HREQ_GATE: assert property (
    !hold_on |=>
    !o_bc_hold_req)
    else $error("hold request seen while disabled");
  AST_HREQ_IN: assert property (
    hold_on |=>
    !o_pin_oe[EBPM_P_HREQ])
    else $error("hold request pin driven");
  AST_HREQ_FOLLOW: assert property (
    hold_on |=>
    o_bc_hold_req == $past(pin_sync[EBPM_P_HREQ]))
    else $error("hold request not sampled");
  AST_HGNT_DRIVE: assert property (
    hold_on |=> o_pin_oe[EBPM_P_HGNT]
    && o_pin[EBPM_P_HGNT] == !$past(o_bc_hold_grant))
    else $error("hold ack pin wrong");
  AST_HOLD_OFF: assert property (
    !hold_on |=>
    !o_bc_hold_grant)
    else $error("ack while hold disabled");
  AST_HOLD_GPIO: assert property (
    !hold_on && !st_ff.alt[EBPM_ALT_COMPARE_OUTPUT_4] |=>
    o_pin_oe[EBPM_P_HREQ] == $past(st_ff.dir[EBPM_P_HREQ]))
    else $error("hold request pin not gpio");
  sequence s_req_idle;
    o_bc_hold_req && !i_bc_busy && hold_on;
  endsequence
  sequence s_req_gone;
    !o_bc_hold_req;
  endsequence
  AST_ACK_IDLE: assert property (
    $rose(o_bc_hold_grant) |->
    $past(!i_bc_busy) && $past(o_bc_hold_req))
    else $error("ack during busy cycle");
  AST_ACK_GIVEN: assert property (
    s_req_idle ##1 s_req_idle |->
    o_bc_hold_grant)
    else $error("ack not given when idle");
  AST_ACK_DROP: assert property (
    s_req_gone |=>
    !o_bc_hold_grant)
    else $error("ack kept after request dropped");

  // ready input, pull-ups and alternate functions
  AST_RDY_GATE: assert property (
    !rdy_on |=>
    o_bc_ready)
    else $error("ready not forced when disabled");
  AST_RDY_IN: assert property (
    rdy_on |=>
    !o_pin_oe[EBPM_P_RDY])
    else $error("ready pin driven");
  AST_RDY_FOLLOW: assert property (
    rdy_on |=>
    o_bc_ready == $past(pin_sync[EBPM_P_RDY]))
    else $error("ready not honoured");
  AST_PULL_EXT: assert property (
    ext_bus |=>
    o_pin_pu == '0)
    else $error("pull-up active on external bus");
  AST_PULL_SINGLE: assert property (
    !ext_bus |=>
    o_pin_pu == $past(st_ff.pull & ~st_ff.dir))
    else $error("pull-up wrong in single-chip");
  AST_CAP_BUS: assert property (
    ext_bus |=>
    !o_cap_in4 && !o_cap_in5)
    else $error("capture input seen on bus pin");
  AST_CMP_OUT: assert property (
    st_ff.alt[EBPM_ALT_COMPARE_OUTPUT_6] && !rdy_on |=> o_pin_oe[EBPM_P_RDY]
    && o_pin[EBPM_P_RDY] == $past(i_cmp_out[2]))
    else $error("compare output 6 not driven");
endmodule
`default_nettype wire

// file: ebpm_ext_party.sv
// Purpose: far-side model, a bus hold requester and a slow device
// Assumes: the bench resolves pad levels and feeds back the ack pad
// Notes: request is kept until acknowledged, ready low for a count
`timescale 1ns/1ps
`default_nettype none
module ebpm_ext_party (
  input wire logic i_clk, // clock
  input wire logic i_want, // requester wants the bus
  input wire logic i_ack_n, // hold acknowledge pad level
  input wire logic i_go, // start a slow access
  input wire logic [3:0] i_waits, // wait cycles to insert
  output logic o_req, // hold request pad drive
  output logic o_rdy // ready pad drive
);
  logic req_ff = 1'b0;
  logic [3:0] cnt_ff = 4'h0;
  always_ff @(posedge i_clk) begin
    req_ff <= i_want | (req_ff & i_ack_n);
  end
  always_ff @(posedge i_clk) begin
    if (i_go) begin
      cnt_ff <= i_waits;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  assign o_req = req_ff;
  assign o_rdy = (cnt_ff == 4'h0);
endmodule
`default_nettype wire

// file: tb_ebpm_pin_mux.sv
// Purpose: self-checking bench for the port 3 pin mux
// Assumes: register port with read data one cycle after the strobe
// Notes: released pads fall back to pull-up or bench-driven levels
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_ebpm_pin_mux;
  import ebpm_pkg::*;
  logic i_clk, i_reset, i_wr, i_rd, ale, rd_n, wr_n, busy;
  logic want, go, req, rdy, hreq, grant, bc_rdy, c4, c5, irq;
  logic [3:0] i_addr, waits;
  logic [7:0] i_wdata, o_rdata;
  logic [1:0] be;
  logic [2:0] cmp;
  logic [6:0] ext_lv, ext, pad, o_pin, o_pin_oe, o_pin_pu;
  int fails = 0;
  int comparisons = 0;
  int n;
  assign ext = {rdy, ext_lv[5], req, ext_lv[3:0]};
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      pad[k] = o_pin_oe[k] ? o_pin[k] : (o_pin_pu[k] ? 1'b1 : ext[k]);
    end
  end
  ebpm_pin_mux dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bc_ale(ale), .i_bc_rd_n(rd_n), .i_bc_wr_n(wr_n), .i_bc_be(be),
    .i_bc_busy(busy), .i_cmp_out(cmp), .o_bc_hold_req(hreq),
    .o_bc_hold_grant(grant), .o_bc_ready(bc_rdy), .o_cap_in4(c4),
    .o_cap_in5(c5), .o_ext_irq10_alt_input(irq), .i_pin(pad),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pin_pu(o_pin_pu));
  ebpm_ext_party party (.i_clk(i_clk), .i_want(want), .i_ack_n(pad[5]),
    .i_go(go), .i_waits(waits), .o_req(req), .o_rdy(rdy));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("register read", e, o_rdata)
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic summarize();
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100us;
    fails++;
    summarize();
  end
  initial begin
    {i_reset, rd_n, wr_n} = 3'b111;
    {i_wr, i_rd, ale, busy, want, go} = 6'h00;
    {i_addr, waits, i_wdata, be, cmp, ext_lv} = 28'h0000000;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int a = 0; a < 4; a++) rdc(a[3:0], 8'h00);
    rdc(EBPM_REG_ALT, 8'h00);
    wr(4'h7, 8'hff);
    rdc(4'h7, 8'h00);
    // gpio in single-chip
    wr(EBPM_REG_DIR, 8'h7f);
    wr(EBPM_REG_DATA, 8'h55);
    step(4);
    `CHK("gpio out", 7'h55, o_pin)
    `CHK("gpio oe", 7'h7f, o_pin_oe)
    wr(EBPM_REG_DIR, 8'h0f);
    wr(EBPM_REG_PULL, 8'h7f);
    step(4);
    `CHK("pull", 7'h70, o_pin_pu)
    rdc(EBPM_REG_PIN, 8'h75);
    wr(EBPM_REG_PULL, 8'h00);
    wr(EBPM_REG_DIR, 8'h00);
    ext_lv <= 7'h05;
    step(6);
    `CHK("alt inputs", 3'b101, {irq, c5, c4})
    rdc(EBPM_REG_PIN, 8'h45);
    wr(EBPM_REG_ALT, 8'h07);
    cmp <= 3'b101;
    step(4);
    `CHK("compare out", 6'h3d, {o_pin_oe[6:4], o_pin[6:4]})
    wr(EBPM_REG_ALT, 8'h00);
    wr(EBPM_REG_PULL, 8'h7f);
    wr(EBPM_REG_MODE, 8'h01);
    {ale, rd_n, wr_n} <= 3'b100;
    step(4);
    `CHK("bus pull", 7'h00, o_pin_pu)
    `CHK("ale rd", 4'hd, {o_pin_oe[1:0], o_pin[1:0]})
    `CHK("strobes off", 2'b00, o_pin_oe[3:2])
    wr(EBPM_REG_MODE, 8'h0d);
    be <= 2'b10;
    step(4);
    `CHK("8-bit", 3'b010, {o_pin_oe[3:2], o_pin[2]})
    wr(EBPM_REG_MODE, 8'h0f);
    for (int b = 0; b < 4; b++) begin
      be <= b[1:0];
      step(3);
      `CHK("16-bit", {2'b11, ~be}, {o_pin_oe[3:2], o_pin[3:2]})
    end
    wr(EBPM_REG_MODE, 8'h07);
    step(4);
    `CHK("high off", 1'b0, o_pin_oe[3])
    wr(EBPM_REG_MODE, 8'h11);
    {busy, want} <= 2'b11;
    step(6);
    `CHK("hold req", 1'b1, hreq)
    `CHK("busy no grant", 3'b011, {grant, o_pin_oe[5], pad[5]})
    busy <= 1'b0;
    want <= 1'b0;
    n = 0;
    while (grant !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    step(1);
    `CHK("grant", 3'b110, {grant, o_pin_oe[5], pad[5]})
    rdc(EBPM_REG_STATUS, 8'h07);
    step(8);
    `CHK("released", 1'b0, grant)
    wr(EBPM_REG_MODE, 8'h01);
    want <= 1'b1;
    step(6);
    `CHK("hold off", 3'b000, {hreq, o_pin_oe[5:4]})
    want <= 1'b0;
    wr(EBPM_REG_MODE, 8'h21);
    waits <= 4'h5;
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk);
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      n = 0;
      for (int k = 0; k < 12; k++) begin
        step(1);
        if (bc_rdy === 1'b0) n++;
      end
      `CHK("wait cycles", (m == 0) ? 5 : 0, n)
      wr(EBPM_REG_MODE, 8'h01);
    end
    summarize();
  end
endmodule
`default_nettype wire
